// ---- shared/ate_map.vh ----
`ifndef ATE_MAP_VH
`define ATE_MAP_VH
// operation field encodings
`define ATE_ATOP_NONE   6'h00
`define ATE_ATOP_SWAP   6'h30
`define ATE_ATOP_CMP    6'h31
`define ATE_FORM_STORE  2'h1
`define ATE_FORM_LOAD   2'h2
`define ATE_BE_BIT      3
// low three operation bits
`define ATE_OP_ADD      3'h0
`define ATE_OP_CLR      3'h1
`define ATE_OP_EOR      3'h2
`define ATE_OP_SET      3'h3
`define ATE_OP_SMAX     3'h4
`define ATE_OP_SMIN     3'h5
`define ATE_OP_UMAX     3'h6
`define ATE_OP_UMIN     3'h7
// response codes
`define ATE_RESP_OKAY   2'h0
`define ATE_RESP_SLVERR 2'h2
// sequencer states
`define ATE_ST_IDLE     2'h0
`define ATE_ST_RMW      2'h1
`define ATE_ST_RSP      2'h2
`endif

// ---- rtl/ate_alu.v ----
`timescale 1ns/1ps
`include "ate_map.vh"
// combinational operand unit, operands right-justified in 64 bits
module ate_alu (
  input  wire [1:0]  i_size,
  input  wire [2:0]  i_op,
  input  wire        i_big,
  input  wire        i_swap,
  input  wire [63:0] i_mem,
  input  wire [63:0] i_snd,
  output reg  [63:0] o_res
);

  // reverse bytes inside the operand width
  function [63:0] bswap(input [63:0] v, input [1:0] s);
    begin
      case (s)
        2'h0:    bswap = v;
        2'h1:    bswap = {48'h0000_0000_0000, v[7:0], v[15:8]};
        2'h2:    bswap = {32'h0000_0000, v[7:0], v[15:8], v[23:16],
                          v[31:24]};
        default: bswap = {v[7:0], v[15:8], v[23:16], v[31:24],
                          v[39:32], v[47:40], v[55:48], v[63:56]};
      endcase
    end
  endfunction

  // keep only the operand bytes
  function [63:0] zmask(input [63:0] v, input [1:0] s);
    begin
      case (s)
        2'h0:    zmask = {56'h00_0000_0000_0000, v[7:0]};
        2'h1:    zmask = {48'h0000_0000_0000, v[15:0]};
        2'h2:    zmask = {32'h0000_0000, v[31:0]};
        default: zmask = v;
      endcase
    end
  endfunction

  // sign-extend from the operand width
  function [63:0] sext(input [63:0] v, input [1:0] s);
    begin
      case (s)
        2'h0:    sext = {{56{v[7]}}, v[7:0]};
        2'h1:    sext = {{48{v[15]}}, v[15:0]};
        2'h2:    sext = {{32{v[31]}}, v[31:0]};
        default: sext = v;
      endcase
    end
  endfunction

  reg        arith;
  reg [63:0] a;
  reg [63:0] b;
  reg [63:0] r;
  reg        s_gt;
  reg        u_gt;

  // byte order only matters for arithmetic ops
  always @* begin
    arith = (i_op == `ATE_OP_ADD) || i_op[2];
    a     = (arith && i_big) ? bswap(i_mem, i_size) : i_mem;
    b     = (arith && i_big) ? bswap(i_snd, i_size) : i_snd;
    a     = zmask(a, i_size);
    b     = zmask(b, i_size);
    s_gt  = $signed(sext(a, i_size)) > $signed(sext(b, i_size));
    u_gt  = a > b;
    case (i_op)
      `ATE_OP_ADD:  r = a + b;
      `ATE_OP_CLR:  r = a & ~b;
      `ATE_OP_EOR:  r = a ^ b;
      `ATE_OP_SET:  r = a | b;
      `ATE_OP_SMAX: r = s_gt ? a : b;
      `ATE_OP_SMIN: r = s_gt ? b : a;
      `ATE_OP_UMAX: r = u_gt ? a : b;
      default:      r = u_gt ? b : a;
    endcase
    r = zmask(r, i_size);
    if (arith && i_big) begin
      r = bswap(r, i_size);
    end
    if (i_swap) begin
      o_res = zmask(i_snd, i_size);
    end else begin
      o_res = r;
    end
  end

endmodule // ate_alu

// ---- rtl/ate_core.v ----
`timescale 1ns/1ps
`include "ate_map.vh"
module ate_core #(
  parameter       ATOMIC_EN = 1,
  parameter       ADDR_W    = 12,
  parameter       ID_W      = 4
) (
  input  wire              i_mclk,
  input  wire              i_srst,
  // atomic request
  input  wire              i_req_valid,
  output wire              o_req_ready,
  input  wire [ID_W-1:0]   i_req_id,
  input  wire [5:0]        i_req_atop,
  input  wire [ADDR_W-1:0] i_req_addr,
  input  wire [1:0]        i_req_size,
  input  wire [63:0]       i_req_data,
  // write response
  output wire              o_bvalid,
  input  wire              i_bready,
  output wire [ID_W-1:0]   o_bid,
  output wire [1:0]        o_bresp,
  // read data response
  output wire              o_rvalid,
  input  wire              i_rready,
  output wire [ID_W-1:0]   o_rid,
  output wire [1:0]        o_rresp,
  output wire [63:0]       o_rdata,
  // plain word access by other agents
  input  wire              i_pl_valid,
  output wire              o_pl_ready,
  input  wire              i_pl_we,
  input  wire [ADDR_W-4:0] i_pl_idx,
  input  wire [7:0]        i_pl_be,
  input  wire [63:0]       i_pl_wdata,
  output wire              o_pl_rvalid,
  output wire [63:0]       o_pl_rdata,
  // configuration property
  output wire              o_atomic_supported
);

  localparam DEPTH = 1 << (ADDR_W - 3);

  reg [63:0]       mem [0:DEPTH-1];
  reg [1:0]        state_q;
  reg              req_ready_q;
  reg              pl_ready_q;
  reg [ID_W-1:0]   id_q;
  reg [5:0]        atop_q;
  reg [1:0]        size_q;
  reg [2:0]        lane_q;
  reg [ADDR_W-4:0] idx_q;
  reg [63:0]       snd_q;
  reg [63:0]       word_q;
  reg              err_q;
  reg              want_r_q;
  reg              bvalid_q;
  reg [1:0]        bresp_q;
  reg              rvalid_q;
  reg [1:0]        rresp_q;
  reg [63:0]       rdata_q;
  reg              pl_rvalid_q;
  reg [63:0]       pl_rdata_q;
  reg              sup_q;

  wire             acc_a;
  wire             acc_p;
  wire [1:0]       form;
  wire             legal;
  wire             misal;
  wire [5:0]       sh;
  wire [63:0]      old_op;
  wire [63:0]      lane_mask;
  wire [63:0]      res;
  wire [63:0]      merged;
  wire             b_left;
  wire             r_left;
  integer          k;

  assign acc_a = req_ready_q & i_req_valid;
  assign acc_p = pl_ready_q & i_pl_valid;

  // request decode
  assign form  = i_req_atop[5:4];
  assign legal = (i_req_atop == `ATE_ATOP_NONE) ||
                 (form == `ATE_FORM_STORE) ||
                 (form == `ATE_FORM_LOAD) ||
                 (i_req_atop == `ATE_ATOP_SWAP);
  assign misal = (i_req_size == 2'h1) ? i_req_addr[0] :
                 (i_req_size == 2'h2) ? |i_req_addr[1:0] :
                 (i_req_size == 2'h3) ? |i_req_addr[2:0] :
                 1'b0;

  // operand position inside the stored word
  assign sh     = {lane_q, 3'h0};
  assign old_op = (word_q >> sh) &
                  ((size_q == 2'h0) ? 64'h0000_0000_0000_00ff :
                   (size_q == 2'h1) ? 64'h0000_0000_0000_ffff :
                   (size_q == 2'h2) ? 64'h0000_0000_ffff_ffff :
                   64'hffff_ffff_ffff_ffff);
  assign lane_mask = ((size_q == 2'h0) ? 64'h0000_0000_0000_00ff :
                      (size_q == 2'h1) ? 64'h0000_0000_0000_ffff :
                      (size_q == 2'h2) ? 64'h0000_0000_ffff_ffff :
                      64'hffff_ffff_ffff_ffff) << sh;
  assign merged = (word_q & ~lane_mask) | ((res << sh) & lane_mask);

  // operation unit
  ate_alu u_alu (
    .i_size (size_q),
    .i_op   (atop_q[2:0]),
    .i_big  (atop_q[`ATE_BE_BIT]),
    .i_swap ((atop_q == `ATE_ATOP_SWAP) ||
             (atop_q == `ATE_ATOP_NONE)),
    .i_mem  (old_op),
    .i_snd  (snd_q),
    .o_res  (res)
  );

  assign b_left = bvalid_q & ~i_bready;
  assign r_left = rvalid_q & ~i_rready;

  // sequencer: the memory is owned by one access at a time
  always @(posedge i_mclk) begin
    if (i_srst) begin
      state_q     <= `ATE_ST_IDLE;
      req_ready_q <= 1'b1;
      pl_ready_q  <= 1'b0;
      id_q        <= {ID_W{1'b0}};
      atop_q      <= 6'h00;
      size_q      <= 2'h0;
      lane_q      <= 3'h0;
      idx_q       <= {(ADDR_W-3){1'b0}};
      snd_q       <= 64'h0000_0000_0000_0000;
      word_q      <= 64'h0000_0000_0000_0000;
      err_q       <= 1'b0;
      want_r_q    <= 1'b0;
      bvalid_q    <= 1'b0;
      bresp_q     <= `ATE_RESP_OKAY;
      rvalid_q    <= 1'b0;
      rresp_q     <= `ATE_RESP_OKAY;
      rdata_q     <= 64'h0000_0000_0000_0000;
      pl_rvalid_q <= 1'b0;
      pl_rdata_q  <= 64'h0000_0000_0000_0000;
      sup_q       <= 1'b0;
    end else begin
      sup_q       <= (ATOMIC_EN != 0);
      pl_rvalid_q <= 1'b0;
      case (state_q)
        `ATE_ST_IDLE: begin
          if (acc_a) begin
            // latch request and the word it targets
            id_q        <= i_req_id;
            atop_q      <= i_req_atop;
            size_q      <= i_req_size;
            lane_q      <= i_req_addr[2:0];
            idx_q       <= i_req_addr[ADDR_W-1:3];
            snd_q       <= i_req_data;
            word_q      <= mem[i_req_addr[ADDR_W-1:3]];
            err_q       <= ~legal | misal |
                           ((ATOMIC_EN == 0) &&
                            (i_req_atop != `ATE_ATOP_NONE));
            want_r_q    <= (i_req_atop != `ATE_ATOP_NONE) &&
                           (form != `ATE_FORM_STORE);
            req_ready_q <= 1'b0;
            pl_ready_q  <= 1'b0;
            state_q     <= `ATE_ST_RMW;
          end else begin
            if (acc_p) begin
              if (i_pl_we) begin
                for (k = 0; k < 8; k = k + 1) begin
                  if (i_pl_be[k]) begin
                    mem[i_pl_idx][k*8 +: 8] <= i_pl_wdata[k*8 +: 8];
                  end
                end
              end else begin
                pl_rdata_q  <= mem[i_pl_idx];
                pl_rvalid_q <= 1'b1;
              end
            end
            // offer the memory to each port in turn
            req_ready_q <= ~req_ready_q;
            pl_ready_q  <= ~pl_ready_q;
          end
        end
        `ATE_ST_RMW: begin
          if (!err_q) begin
            mem[idx_q] <= merged;
          end
          // responses raised on the same edge as the write above
          bvalid_q <= 1'b1;
          bresp_q  <= err_q ? `ATE_RESP_SLVERR : `ATE_RESP_OKAY;
          rvalid_q <= want_r_q;
          rresp_q  <= err_q ? `ATE_RESP_SLVERR : `ATE_RESP_OKAY;
          rdata_q  <= err_q ? 64'h0000_0000_0000_0000 : old_op;
          state_q  <= `ATE_ST_RSP;
        end
        `ATE_ST_RSP: begin
          bvalid_q <= b_left;
          rvalid_q <= r_left;
          if (!b_left && !r_left) begin
            state_q    <= `ATE_ST_IDLE;
            pl_ready_q <= 1'b1;
          end
        end
        default: begin
          state_q     <= `ATE_ST_IDLE;
          req_ready_q <= 1'b1;
          pl_ready_q  <= 1'b0;
        end
      endcase
    end
  end

  // outputs straight from flops
  assign o_req_ready        = req_ready_q;
  assign o_pl_ready         = pl_ready_q;
  assign o_bvalid           = bvalid_q;
  assign o_bid              = id_q;
  assign o_bresp            = bresp_q;
  assign o_rvalid           = rvalid_q;
  assign o_rid              = id_q;
  assign o_rresp            = rresp_q;
  assign o_rdata            = rdata_q;
  assign o_pl_rvalid        = pl_rvalid_q;
  assign o_pl_rdata         = pl_rdata_q;
  assign o_atomic_supported = sup_q;

endmodule // ate_core

// ---- verification/ate_core_sva.sv ----
`timescale 1ns/1ps
`include "ate_map.vh"
module ate_core_sva #(
  parameter ID_W = 4
) (
  input wire            i_mclk,
  input wire            i_srst,
  input wire            i_req_valid,
  input wire            o_req_ready,
  input wire [ID_W-1:0] i_req_id,
  input wire [5:0]      i_req_atop,
  input wire            o_bvalid,
  input wire [ID_W-1:0] o_bid,
  input wire            o_rvalid,
  input wire [1:0]      o_rresp,
  input wire [63:0]     o_rdata,
  input wire            o_pl_ready,
  input wire            o_atomic_supported
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // a request is taken on valid and ready together
  wire take = i_req_valid && o_req_ready;
  property p_rsp; take |-> ##2 o_bvalid; endproperty
  a_rsp: assert property (p_rsp)
    else $error("write response late");
  property p_id; take |-> ##2 (o_bid == $past(i_req_id, 2)); endproperty
  a_id: assert property (p_id)
    else $error("response id differs");
  property p_st;
    take && i_req_atop[5:4] == `ATE_FORM_STORE |-> ##1 !o_rvalid [*3];
  endproperty
  a_st: assert property (p_st)
    else $error("store gave read data");
  property p_ld;
    take && i_req_atop[5:4] != `ATE_FORM_STORE
      && i_req_atop != `ATE_ATOP_NONE |-> ##2 o_rvalid;
  endproperty
  a_ld: assert property (p_ld)
    else $error("read data late");
  property p_cmp;
    take && i_req_atop == `ATE_ATOP_CMP |-> ##2 o_rvalid
      && o_rresp == `ATE_RESP_SLVERR && o_rdata == 64'h0000_0000_0000_0000;
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("compare not refused");
  property p_busy; o_bvalid || o_rvalid |-> !o_pl_ready && !o_req_ready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("access open while busy");
  property p_excl; !(o_pl_ready && o_req_ready); endproperty
  a_excl: assert property (p_excl)
    else $error("both ports ready");
  property p_sup; !$past(i_srst) |-> o_atomic_supported; endproperty
  a_sup: assert property (p_sup)
    else $error("support flag low");
endmodule // ate_core_sva
bind ate_core ate_core_sva #(.ID_W(ID_W)) i_ate_core_sva (.*);

// ---- verification/ate_req_model.sv ----
`timescale 1ns/1ps
module ate_req_model (
  input  wire          i_mclk,
  input  wire          i_req_ready,
  output logic         o_req_valid,
  output logic [3:0]   o_req_id,
  output logic [5:0]   o_req_atop,
  output logic [11:0]  o_req_addr,
  output logic [1:0]   o_req_size,
  output logic [63:0]  o_req_data,
  output logic         o_bready,
  output logic         o_rready
);
  // idle lines at time zero
  initial begin
    {o_req_valid, o_req_id, o_req_atop, o_req_addr} = 0;
    {o_req_size, o_req_data, o_bready, o_rready} = 0;
  end
  // responses are taken promptly or slowly at random
  always @(negedge i_mclk) {o_bready, o_rready} = 2'($urandom);
  // one request, held until ready is seen, then lines scrambled
  task send(input [3:0] id, input [5:0] op, input [11:0] a,
            input [1:0] sz, input [63:0] d);
    int k;
    // let an edge pass so valid never falls and rises in one step
    @(negedge i_mclk);
    {o_req_id, o_req_atop, o_req_addr, o_req_size} = {id, op, a, sz};
    o_req_data = d;
    o_req_valid = 1'b1;
    for (k = 0; k < 60 && !i_req_ready; k++) @(negedge i_mclk);
    if (!i_req_ready) tb.close_out(1);
    @(negedge i_mclk);
    o_req_valid = 1'b0;
    o_req_data = ~d;
    o_req_addr = ~a;
  endtask
endmodule // ate_req_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`include "ate_map.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH %0t value differs", $time); end end
module tb;
  logic        i_mclk = 0, i_srst = 1, i_pl_valid = 0, i_pl_we = 0;
  logic [8:0]  i_pl_idx = 0;
  logic [7:0]  i_pl_be = 0;
  logic [63:0] i_pl_wdata = 0, m, s, ms, lm;
  wire         i_req_valid, i_bready, i_rready, o_req_ready, o_bvalid;
  wire         o_rvalid, o_pl_ready, o_pl_rvalid, o_atomic_supported;
  wire [3:0]   i_req_id, o_bid, o_rid;
  wire [5:0]   i_req_atop;
  wire [11:0]  i_req_addr;
  wire [1:0]   i_req_size, o_bresp, o_rresp;
  wire [63:0]  i_req_data, o_rdata, o_pl_rdata;
  int          n_mismatch = 0, n_tests = 0, e, f, op, k, z;
  logic [5:0]  qb[$];
  logic [69:0] qr[$];
  logic [63:0] qp[$];
  ate_core i_ate_core (.*);
  ate_req_model i_ate_req_model (.i_mclk, .i_req_ready(o_req_ready),
    .o_req_valid(i_req_valid), .o_req_id(i_req_id), .o_req_atop(i_req_atop),
    .o_req_addr(i_req_addr), .o_req_size(i_req_size),
    .o_req_data(i_req_data), .o_bready(i_bready), .o_rready(i_rready));
  initial forever #12.5 i_mclk = ~i_mclk;
  function automatic [63:0] rev(input [63:0] x);
    for (int i = 0; i < 8; i++) rev[8*i +: 8] = x[56-8*i +: 8];
  endfunction
  // reference operation, byte order applied to arithmetic only
  function automatic [63:0] alu(input [2:0] o, input [63:0] a, b);
    case (o)
      3'h0: alu = a + b;
      3'h1: alu = a & ~b;
      3'h2: alu = a ^ b;
      3'h3: alu = a | b;
      3'h4: alu = ($signed(a) > $signed(b)) ? a : b;
      3'h5: alu = ($signed(a) < $signed(b)) ? a : b;
      3'h6: alu = (a > b) ? a : b;
      default: alu = (a < b) ? a : b;
    endcase
  endfunction
  // operation on the low operand bytes, top-aligned so sign comes free
  function automatic [63:0] op_sz(input [2:0] o, input be, input [1:0] sz,
                                  input [63:0] a, b);
    int t;
    t = 64 - (8 << sz);
    if (be && (o == 0 || o > 3)) begin
      a = rev(a) >> t;
      b = rev(b) >> t;
    end
    op_sz = alu(o, a << t, b << t) >> t;
    if (be && (o == 0 || o > 3)) op_sz = rev(op_sz) >> t;
  endfunction
  // plain access to word five; a read notes the model word
  task pl(input we, input [63:0] d);
    if (we) m = d;
    else qp.push_back(m);
    {i_pl_valid, i_pl_we, i_pl_idx, i_pl_be, i_pl_wdata} =
      {1'b1, we, 9'h005, 8'hff, d};
    for (k = 0; k < 60 && !o_pl_ready; k++) @(negedge i_mclk);
    if (!o_pl_ready) close_out(1);
    @(negedge i_mclk);
    i_pl_valid = 1'b0;
    i_pl_wdata = ~d;
  endtask
  // atomic on word five; notes expected responses first
  task at(input [5:0] o, input [2:0] ln, input [1:0] sz,
          input [63:0] d, input [63:0] nw, input err);
    logic [3:0]  id;
    logic [63:0] mk;
    id = 4'($urandom);
    mk = (64'h0000_0000_0000_0001 << (8 << sz)) - 1;
    qb.push_back({id, err ? `ATE_RESP_SLVERR : `ATE_RESP_OKAY});
    if (o[5:4] != `ATE_FORM_STORE && o != `ATE_ATOP_NONE)
      qr.push_back({id, err ? {`ATE_RESP_SLVERR, 64'h0000_0000_0000_0000} :
        {`ATE_RESP_OKAY, (m >> (8 * ln)) & mk}});
    if (!err) m = nw;
    i_ate_req_model.send(id, o, {9'h005, ln}, sz, d);
  endtask
  // response monitor takes the oldest note
  always @(posedge i_mclk) begin
    if (o_bvalid && i_bready)
      `CHK({o_bid, o_bresp}, qb.pop_front())
    if (o_rvalid && i_rready)
      `CHK({o_rid, o_rresp, o_rdata}, qr.pop_front())
    if (o_pl_rvalid) `CHK(o_pl_rdata, qp.pop_front())
  end
  initial begin
    void'($urandom(2869));
    repeat (8) @(negedge i_mclk);
    i_srst = 1'b0;
    @(negedge i_mclk);
    `CHK(o_atomic_supported, 1'b1)
    pl(1, {$urandom, $urandom});
    for (e = 0; e < 2; e++)
      for (f = 1; f < 3; f++)
        for (op = 0; op < 8; op++) begin
          s = {$urandom, $urandom};
          ms = (e && (op == 0 || op > 3)) ?
            rev(alu(op, rev(m), rev(s))) : alu(op, m, s);
          at({f[1:0], e[0], op[2:0]}, 0, 3, s, ms, 0);
          pl(0, 0);
        end
    $display("test ops done");
    for (e = 0; e < 4; e++) begin
      f = ($urandom << e) & 7;
      s = {$urandom, $urandom} & ((64'h0000_0000_0000_0001 << (8 << e)) - 1);
      ms = (m & ~(((64'h0000_0000_0000_0001 << (8 << e)) - 1) << (8 * f)))
        | (s << (8 * f));
      at(`ATE_ATOP_SWAP, f[2:0], e[1:0], s, ms, 0);
      pl(0, 0);
    end
    $display("test swap sizes done");
    for (e = 0; e < 24; e++) begin
      z = e % 3;
      f = ($urandom << z) & 7;
      op = $urandom & 7;
      lm = (64'h0000_0000_0000_0001 << (8 << z)) - 1;
      s = {$urandom, $urandom} & lm;
      ms = op_sz(op[2:0], e[3], z[1:0], (m >> (8 * f)) & lm, s);
      ms = (m & ~(lm << (8 * f))) | (ms << (8 * f));
      at({e[4] ? `ATE_FORM_LOAD : `ATE_FORM_STORE, e[3], op[2:0]},
         f[2:0], z[1:0], s, ms, 0);
      pl(0, 0);
    end
    $display("test small sizes done");
    s = {$urandom, $urandom};
    at(`ATE_ATOP_NONE, 0, 3, s, s, 0);
    at(6'h05, 0, 3, s, 0, 1);
    at(`ATE_ATOP_CMP, 0, 3, {$urandom, $urandom}, 0, 1);
    at(`ATE_ATOP_SWAP, 1, 1, 64'h0000_0000_0000_a5c3, 0, 1);
    pl(0, 0);
    $display("test refusals done");
    for (k = 0; k < 300 && qb.size() + qr.size() + qp.size() > 0; k++)
      @(negedge i_mclk);
    close_out(qb.size() + qr.size() + qp.size() > 0);
  end
  task close_out(input bit hung);
    if (hung) n_mismatch++;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
endmodule // tb
